// File: bench/core_model.sv
// Purpose: Return stack of the core, seen by the block as stack_full
// Assumes: one push per vec_ack, pops come from the bench as returns
// Notes:   Depth is small so a full stack is reached after one vector
`default_nettype none
module core_model #(
  parameter int DEPTH = 1
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Stack traffic
  input  wire logic vec_ack,
  input  wire logic pop,
  output logic      stack_full
);
  timeunit 1ns;
  timeprecision 1ps;
  int depth;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      depth <= 0;
    else
      depth <= depth + int'(vec_ack) - int'(pop && depth > 0);
  end
  // No room left holds off vectoring in the block
  assign stack_full = (depth >= DEPTH);
endmodule // core_model
`default_nettype wire

// File: bench/tb_program_rom_vectors_table_read.sv
// Purpose: Self-checking bench for code store, entry points and table reads
// Assumes: AW 12, DW 15, default entry addresses
// Notes:   Inputs change after rising edges; core outputs sampled on falling edges, APB results just after rising edges
`include "prog_rom_regs.svh"
`default_nettype none
module tb_program_rom_vectors_table_read;
  timeunit 1ns;
  timeprecision 1ps;
  import prog_rom_pkg::*;
  localparam logic [11:0] VECS [5] = '{`VEC_EXT, `VEC_TMR0, `VEC_TMR1, `VEC_TMR2, `VEC_TBASE};
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready;
  logic               pslverr;
  logic               err;
  core_ctl_s          ctl = '0;
  logic               dev_reset = 1'b0;
  logic               stack_full;
  logic               pop = 1'b0;
  logic [11:0]        pc;
  logic [14:0]        instr;
  logic               table_busy;
  logic               vec_ack;
  logic               irq;
  table_out_s         tbl_out;
  logic               ext_int_pin = 1'b0;
  logic               tbase_ovf = 1'b0;
  logic [2:0]         tmr_ovf = 3'h0;
  int                 err_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  program_rom_vectors_table_read #(.AW(12), .DW(15)) dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctl(ctl), .dev_reset(dev_reset), .stack_full(stack_full), .pc(pc), .instr(instr),
    .table_busy(table_busy), .vec_ack(vec_ack), .tbl_out(tbl_out),
    .ext_int_pin(ext_int_pin), .tmr_ovf(tmr_ovf), .tbase_ovf(tbase_ovf), .irq(irq));
  core_model #(.DEPTH(1)) stk (
    .clk(clk), .reset_n(reset_n), .vec_ack(vec_ack), .pop(pop), .stack_full(stack_full));

  always #5 clk = ~clk;
  // A hang is cut short well past the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; an idle cycle follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic jump_to(input logic [11:0] a);
    ctl.jump <= 1'b1;
    ctl.jump_addr <= a;
    @(posedge clk);
    ctl.jump <= 1'b0;
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("pc after reset", pc, `VEC_RESET);
    @(posedge clk);
    jump_to(12'h123);
    ctl.advance <= 1'b1;
    @(negedge clk);
    chk("pc after jump", pc, 12'h123);
    @(posedge clk);
    ctl.advance <= 1'b0;
    dev_reset <= 1'b1;
    @(negedge clk);
    chk("pc after advance", pc, 12'h124);
    @(posedge clk);
    dev_reset <= 1'b0;
    @(negedge clk);
    chk("pc after device reset", pc, `VEC_RESET);
    @(posedge clk);
  endtask

  task automatic table_rd(input logic last, input logic [7:0] dst, input logic [7:0] lo,
                          input logic [7:0] hi);
    ctl.table_rd <= 1'b1;
    ctl.table_last <= last;
    ctl.operand <= dst;
    @(posedge clk);
    ctl.table_rd <= 1'b0;
    @(negedge clk);
    chk("busy second cycle", table_busy, 1'b1);
    chk("valid early", tbl_out.valid, 1'b0);
    @(negedge clk);
    chk("valid", tbl_out.valid, 1'b1);
    chk("dest", tbl_out.dest, dst);
    chk("low byte", tbl_out.data, lo);
    @(posedge clk);
    apb(1'b0, `OFS_TBL_HIGH, 32'h0000_0000);
    chk("high result", rd, hi);
  endtask

  task automatic t_table();
    apb(1'b1, `OFS_LOAD_ADDR, 32'h0000_0321);
    apb(1'b1, `OFS_LOAD_DATA, 32'h0000_5A3C);
    apb(1'b1, `OFS_LOAD_ADDR, 32'h0000_0F21);
    apb(1'b1, `OFS_LOAD_DATA, 32'hFFFF_FFA5);
    apb(1'b1, `OFS_TBL_LOW, 32'h0000_0021);
    apb(1'b0, `OFS_TBL_LOW, 32'h0000_0000);
    chk("low pointer", rd, 8'h21);
    jump_to(12'h321);
    @(posedge clk);
    @(negedge clk);
    chk("fetched word", instr, 32'h0000_5A3C);
    @(posedge clk);
    jump_to(12'h345);
    table_rd(1'b0, 8'h40, 8'h3C, 8'h5A);
    table_rd(1'b1, 8'h41, 8'hA5, 8'h7F);
    apb(1'b1, `OFS_TBL_HIGH, 32'h0000_0011);
    apb(1'b0, `OFS_TBL_HIGH, 32'h0000_0000);
    chk("high result kept", rd, 8'h7F);
  endtask

  task automatic t_edges();
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, `OFS_CTRL, m);
      apb(1'b1, `OFS_INT_CLR, 32'h0000_001F);
      ext_int_pin <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, `OFS_INT_STAT, 32'h0000_0000);
      chk("rising edge", rd, 32'(m != 0));
      chk("masked irq", irq, 1'b0);
      apb(1'b1, `OFS_INT_CLR, 32'h0000_0001);
      ext_int_pin <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, `OFS_INT_STAT, 32'h0000_0000);
      chk("falling edge", rd, 32'(m != 1));
    end
  endtask

  task automatic ev(input int k);
    if (k == 0)
      ext_int_pin <= ~ext_int_pin;
    else if (k == 4)
      tbase_ovf <= 1'b1;
    else
      tmr_ovf[k-1] <= 1'b1;
    @(posedge clk);
    tbase_ovf <= 1'b0;
    tmr_ovf <= 3'h0;
  endtask

  task automatic wait_ack(input logic [11:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while (vec_ack !== 1'b1 && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    chk("ack", vec_ack, 1'b1);
    @(negedge clk);
    chk("vector", pc, v);
    @(posedge clk);
  endtask

  task automatic pop_stack();
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_vectors();
    apb(1'b1, `OFS_CTRL, 32'h0000_0002);
    apb(1'b1, `OFS_INT_CLR, 32'h0000_001F);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `OFS_INT_EN, 32'h1 << k);
      ev(k);
      wait_ack(VECS[k]);
      pop_stack();
    end
  endtask

  task automatic t_stack();
    int n;
    n = 0;
    apb(1'b1, `OFS_INT_EN, 32'h0000_000C);
    ev(2);
    wait_ack(`VEC_TMR1);
    ev(3);
    repeat (6)
    begin
      @(negedge clk);
      n += int'(vec_ack === 1'b1);
    end
    chk("no ack when full", n, 0);
    chk("flag kept", irq, 1'b1);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    wait_ack(`VEC_TMR2);
    pop_stack();
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_table();
    t_edges();
    t_vectors();
    t_stack();
    t_unmapped();
    close_out();
  end
endmodule // tb_program_rom_vectors_table_read
`default_nettype wire

// File: hdl/prog_rom_pkg.sv
// Purpose: Types shared by the code store unit and its users
// Assumes: prog_rom_regs.svh supplies the widths
// Notes:   Structs carry the core-side request and table answer
`include "prog_rom_regs.svh"
`default_nettype none
package prog_rom_pkg;
  typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH} edge_sel_e;
  typedef struct packed {
    logic                     advance;
    logic                     jump;
    logic [`ADDR_MAX_W-1:0]   jump_addr;
    logic                     table_rd;
    logic                     table_last;
    logic [`LOW_BYTE_W-1:0]   operand;
  } core_ctl_s;
  typedef struct packed {
    logic                     valid;
    logic [`LOW_BYTE_W-1:0]   dest;
    logic [`LOW_BYTE_W-1:0]   data;
  } table_out_s;
endpackage
`default_nettype wire

// File: hdl/prog_rom_regs.svh
// Purpose: Register offsets, field positions and fixed addresses of the code store unit
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the package and the design file
`ifndef PROG_ROM_REGS_SVH
`define PROG_ROM_REGS_SVH
`define APB_AW        8
`define OFS_TBL_LOW   8'h00
`define OFS_TBL_HIGH  8'h04
`define OFS_CTRL      8'h08
`define OFS_INT_STAT  8'h0C
`define OFS_INT_CLR   8'h10
`define OFS_INT_EN    8'h14
`define OFS_LOAD_ADDR 8'h18
`define OFS_LOAD_DATA 8'h1C
`define OFS_PC        8'h20
`define CTRL_EDGE_LSB 0
`define CTRL_EDGE_W   2
`define EV_EXT        0
`define EV_TMR0       1
`define EV_TMR1       2
`define EV_TMR2       3
`define EV_TBASE      4
`define NUM_EV        5
`define TMR_NUM       3
`define PAGE_LSB      8
`define LOW_BYTE_W    8
`define ADDR_MAX_W    12
`define VEC_RESET     12'h000
`define VEC_EXT       12'h004
`define VEC_TMR0      12'h008
`define VEC_TMR1      12'h00C
`define VEC_TMR2      12'h010
`define VEC_TBASE     12'h014
`define ROM_AW_DEF    12
`define ROM_DW_DEF    15
`endif

// File: hdl/program_rom_vectors_table_read.sv
// Purpose: Code store, fixed entry points and table-read path of a small 8-bit controller
// Assumes: core control and the overflow inputs arrive on clk; only the external event pin is synchronised here
// Notes:   Code words are loaded over APB since programming is outside this block
// How it works
// - Code store is 1K x14, 2K x15 or 4K x15, addressed by the PC.
// - Releasing any reset loads the PC with the reset entry address.
// - Enabled external edge with stack room vectors to the external entry.
// - External edge sensitivity selects falling, rising or both edges.
// - Enabled timer overflow with stack room vectors to that timer's entry.
// - Enabled time base overflow with stack room vectors to its entry.
// - Table low pointer gives the low eight table address bits.
// - Two table reads: current PC page or last code page.
// - Upper table bits are PC bits 8..11, or all ones for last page.
// - Table read writes the word's low byte to the operand location.
// - Table read loads the upper word part, unused bits zero, into high result.
// - Table address width is 10, 11 or 12 bits with the store size.
// - Table high result is read-only; only table reads change it.
// - Every table read takes two instruction cycles.
// - With a full stack the flag stays set; vectoring waits for room.
//
// The APB register port and the placing of the registers were left to the implementer.
`include "prog_rom_regs.svh"
`default_nettype none
module program_rom_vectors_table_read
  import prog_rom_pkg::*;
#(
  parameter int                    AW        = `ROM_AW_DEF,
  parameter int                    DW        = `ROM_DW_DEF,
  parameter logic [`ADDR_MAX_W-1:0] RST_VEC  = `VEC_RESET,
  parameter logic [`ADDR_MAX_W-1:0] EXT_VEC  = `VEC_EXT,
  parameter logic [`ADDR_MAX_W-1:0] TMR0_VEC = `VEC_TMR0,
  parameter logic [`ADDR_MAX_W-1:0] TMR1_VEC = `VEC_TMR1,
  parameter logic [`ADDR_MAX_W-1:0] TMR2_VEC = `VEC_TMR2,
  parameter logic [`ADDR_MAX_W-1:0] TB_VEC   = `VEC_TBASE
)
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`APB_AW-1:0]        paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Core side
  input  wire prog_rom_pkg::core_ctl_s   ctl,
  input  wire logic                      dev_reset,
  input  wire logic                      stack_full,
  output var  logic [AW-1:0]             pc,
  output var  logic [DW-1:0]             instr,
  output logic                           table_busy,
  output logic                           vec_ack,
  output var  prog_rom_pkg::table_out_s  tbl_out,
  // Event sources
  input  wire logic                      ext_int_pin,
  input  wire logic [`TMR_NUM-1:0]       tmr_ovf,
  input  wire logic                      tbase_ovf,
  output logic                           irq
);
  import prog_rom_pkg::*;

  localparam int DEPTH = 1 << AW;
  localparam int PW    = AW - `PAGE_LSB;

  logic [DW-1:0]           mem [DEPTH];
  logic [`LOW_BYTE_W-1:0]  table_low_pointer;
  logic [`LOW_BYTE_W-1:0]  table_high_result;
  edge_sel_e               edge_sel;
  logic [`NUM_EV-1:0]      int_stat;
  logic [`NUM_EV-1:0]      int_en;
  logic [AW-1:0]           load_addr;
  logic                    ext_s1;
  logic                    ext_s2;
  logic                    ext_prev;
  logic [`NUM_EV-1:0]      ev;
  logic [`NUM_EV-1:0]      pend;
  logic [`NUM_EV-1:0]      ack_mask;
  logic [`NUM_EV-1:0]      clr_mask;
  logic                    take;
  logic [2:0]              sel;
  logic [AW-1:0]           tbl_addr;
  logic [`LOW_BYTE_W-1:0]  tbl_dest;
  logic                    tbl_start;
  logic                    apb_wr;
  logic                    apb_setup;
  logic [`ADDR_MAX_W-1:0]  vec_addr;
  logic [PW-1:0]           pc_page;

  function automatic logic hit(input logic [`APB_AW-1:0] a, input logic [`APB_AW-1:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic mapped(input logic [`APB_AW-1:0] a);
    return hit(a, `OFS_TBL_LOW) || hit(a, `OFS_TBL_HIGH) || hit(a, `OFS_CTRL)
        || hit(a, `OFS_INT_STAT) || hit(a, `OFS_INT_CLR) || hit(a, `OFS_INT_EN)
        || hit(a, `OFS_LOAD_ADDR) || hit(a, `OFS_LOAD_DATA) || hit(a, `OFS_PC);
  endfunction

  function automatic logic edge_hit(input edge_sel_e m, input logic r, input logic f);
    unique case (m)
      EDGE_FALL: return f;
      EDGE_RISE: return r;
      EDGE_BOTH: return r | f;
      default:   return r | f;
    endcase
  endfunction

  function automatic logic [`ADDR_MAX_W-1:0] vec_of(input logic [2:0] i);
    unique case (i)
      3'(`EV_EXT):  return EXT_VEC;
      3'(`EV_TMR0): return TMR0_VEC;
      3'(`EV_TMR1): return TMR1_VEC;
      3'(`EV_TMR2): return TMR2_VEC;
      default:      return TB_VEC;
    endcase
  endfunction

  // APB: zero wait, read data captured in the setup phase
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & mapped(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped(paddr);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= '0;
    else if (apb_setup && !pwrite)
    begin
      prdata <= '0;
      if (hit(paddr, `OFS_TBL_LOW))   prdata[`LOW_BYTE_W-1:0] <= table_low_pointer;
      if (hit(paddr, `OFS_TBL_HIGH))  prdata[`LOW_BYTE_W-1:0] <= table_high_result;
      if (hit(paddr, `OFS_CTRL))      prdata[`CTRL_EDGE_W-1:0] <= edge_sel;
      if (hit(paddr, `OFS_INT_STAT))  prdata[`NUM_EV-1:0] <= int_stat;
      if (hit(paddr, `OFS_INT_EN))    prdata[`NUM_EV-1:0] <= int_en;
      if (hit(paddr, `OFS_LOAD_ADDR)) prdata[AW-1:0] <= load_addr;
      if (hit(paddr, `OFS_PC))        prdata[AW-1:0] <= pc;
    end
  end

  // Software-written control
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      table_low_pointer <= '0;
      edge_sel          <= EDGE_FALL;
      int_en            <= '0;
    end
    else if (apb_wr)
    begin
      if (hit(paddr, `OFS_TBL_LOW)) table_low_pointer <= pwdata[`LOW_BYTE_W-1:0];
      if (hit(paddr, `OFS_CTRL))
        edge_sel <= edge_sel_e'(pwdata[`CTRL_EDGE_LSB +: `CTRL_EDGE_W]);
      if (hit(paddr, `OFS_INT_EN)) int_en <= pwdata[`NUM_EV-1:0];
    end
  end

  // Code loading stands in for OTP programming; address steps after each word
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      load_addr <= '0;
    else if (apb_wr && hit(paddr, `OFS_LOAD_ADDR))
      load_addr <= pwdata[AW-1:0];
    else if (apb_wr && hit(paddr, `OFS_LOAD_DATA))
      load_addr <= load_addr + AW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (apb_wr && hit(paddr, `OFS_LOAD_DATA))
      mem[load_addr] <= pwdata[DW-1:0];
  end

  // External pin crosses in through two flops before edge detection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_s1   <= ext_int_pin;
      ext_s2   <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  always_comb
  begin
    ev            = '0;
    ev[`EV_EXT]   = edge_hit(edge_sel, ext_s2 & ~ext_prev, ~ext_s2 & ext_prev);
    ev[`EV_TBASE] = tbase_ovf;
    for (int i = 0; i < `TMR_NUM; i++)
      ev[`EV_TMR0 + i] = tmr_ovf[i];
  end

  always_comb
  begin
    clr_mask = '0;
    if (apb_wr && hit(paddr, `OFS_INT_CLR))
      clr_mask = pwdata[`NUM_EV-1:0];
  end

  // Flags stay set while the stack is full; a new event beats any clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      int_stat <= '0;
    else
      int_stat <= (int_stat & ~clr_mask & ~ack_mask) | ev;
  end

  assign pend = int_stat & int_en;
  assign irq  = |pend;

  // Lowest index wins: external, timers in order, then time base
  always_comb
  begin
    sel = 3'(`EV_TBASE);
    for (int i = `NUM_EV - 1; i >= 0; i--)
      if (pend[i])
        sel = 3'(i);
  end

  assign take    = |pend & ~stack_full & ~table_busy & ~dev_reset;
  assign vec_ack = take;

  // Held on a net so that only the implemented low bits reach the PC
  assign vec_addr = vec_of(sel);

  always_comb
  begin
    ack_mask = '0;
    if (take)
      ack_mask[sel] = 1'b1;
  end

  // Program counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pc <= RST_VEC[AW-1:0];
    else if (dev_reset)
      pc <= RST_VEC[AW-1:0];
    else if (table_busy)
      pc <= pc;
    else if (take)
      pc <= vec_addr[AW-1:0];
    else if (ctl.jump)
      pc <= ctl.jump_addr[AW-1:0];
    else if (ctl.advance)
      pc <= pc + AW'(1);
  end

  // Fetch keeps running during the table cycle on its own read path
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      instr <= '0;
    else
      instr <= mem[pc];
  end

  // Table read: first cycle forms the address, second reads the word
  assign tbl_start = ctl.table_rd & ~table_busy & ~dev_reset;
  assign pc_page   = pc[AW-1:`PAGE_LSB];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      table_busy <= 1'b0;
      tbl_addr   <= '0;
      tbl_dest   <= '0;
    end
    else
    begin
      table_busy <= tbl_start;
      if (tbl_start)
      begin
        tbl_dest <= ctl.operand;
        if (ctl.table_last)
          tbl_addr <= {{PW{1'b1}}, table_low_pointer};
        else
          tbl_addr <= {pc[AW-1:`PAGE_LSB], table_low_pointer};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tbl_out           <= '0;
      table_high_result <= '0;
    end
    else
    begin
      tbl_out.valid <= table_busy;
      if (table_busy)
      begin
        tbl_out.dest      <= tbl_dest;
        tbl_out.data      <= mem[tbl_addr][`LOW_BYTE_W-1:0];
        table_high_result <= `LOW_BYTE_W'(mem[tbl_addr] >> `LOW_BYTE_W);
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence tbl_go_s;
    tbl_start;
  endsequence

  sequence tbl_done_s;
    table_busy ##1 (tbl_out.valid && !table_busy);
  endsequence

  reset_entry_a: assert property (dev_reset |=> pc == RST_VEC[AW-1:0])
    else $error("reset did not load the reset entry");
  ext_entry_a: assert property (take && sel == 3'(`EV_EXT) |=> pc == EXT_VEC[AW-1:0])
    else $error("external interrupt missed its entry");
  edge_rise_a: assert property (edge_sel == EDGE_RISE && $rose(ext_s2)
      |=> int_stat[`EV_EXT])
    else $error("rising edge not recorded");
  tmr_entry_a: assert property (take && sel == 3'(`EV_TMR1) |=> pc == TMR1_VEC[AW-1:0])
    else $error("timer interrupt missed its entry");
  tbase_entry_a: assert property (take && sel == 3'(`EV_TBASE)
      |=> pc == TB_VEC[AW-1:0] && (!int_stat[`EV_TBASE] || $past(tbase_ovf)))
    else $error("time base interrupt missed its entry");
  stack_hold_a: assert property (stack_full && |pend && clr_mask == '0 |=> |int_stat)
    else $error("pending flag lost while stack full");
  last_page_a: assert property (tbl_start && ctl.table_last
      |=> tbl_addr[AW-1:`PAGE_LSB] == {PW{1'b1}})
    else $error("last page bits not forced high");
  table_two_a: assert property (tbl_go_s |=> tbl_done_s)
    else $error("table read did not finish in two cycles");
  pc_hold_a: assert property (table_busy && !dev_reset |=> $stable(pc))
    else $error("program counter moved during table cycle");
  high_ro_a: assert property (!table_busy |=> $stable(table_high_result))
    else $error("table high result changed outside a table read");
  high_zero_a: assert property (tbl_out.valid
      |-> (table_high_result >> (DW - `LOW_BYTE_W)) == '0)
    else $error("unused high bits not zero");

  // Entry points, stack and table gating, edges, table page and load stepping
  tmr0_entry_a: assert property (take && sel == 3'(`EV_TMR0) |=> pc == TMR0_VEC[AW-1:0])
    else $error("first timer interrupt missed its entry");
  tmr2_entry_a: assert property (take && sel == 3'(`EV_TMR2) |=> pc == TMR2_VEC[AW-1:0])
    else $error("third timer interrupt missed its entry");
  stack_gate_a: assert property (stack_full |-> !vec_ack)
    else $error("vector taken with a full stack");
  table_block_a: assert property (table_busy |-> !vec_ack)
    else $error("vector taken during a table cycle");
  edge_fall_a: assert property (edge_sel == EDGE_FALL && $fell(ext_s2)
      |=> int_stat[`EV_EXT])
    else $error("falling edge not recorded");
  edge_both_a: assert property (edge_sel == EDGE_BOTH && $changed(ext_s2)
      |=> int_stat[`EV_EXT])
    else $error("edge not recorded in both-edge mode");
  cur_page_a: assert property (tbl_start && !ctl.table_last
      |=> tbl_addr == {$past(pc_page), $past(table_low_pointer)})
    else $error("current page table address wrong");
  load_step_a: assert property (apb_wr && hit(paddr, `OFS_LOAD_DATA)
      |=> load_addr == $past(load_addr) + AW'(1))
    else $error("load address did not step");

endmodule // program_rom_vectors_table_read
`default_nettype wire
